// file: css_selector.sv
// css_selector: command source selector with apb settings registers.
// assumes all inputs synchronous to clock; comm requests are pulses.
//
// The register offsets and the APB interface to the registers were left to the implementer.
`timescale 1ns/10ps
// Functional notes
// - run setting 0 takes start/stop from comms, 1 from terminals.
// - speed setting 0, the reset value, takes frequency from comms.
// - speed 1 ignores comm frequency and uses analog; 2 takes comms.
// - network source 0 is option, 1 is rs485, 9999 picks option if fitted.
// - panel source 1 is rs485, 2 the panel connector, 3 the usb port.
// - auto mode with option fitted refuses rs485 writes, runs, frequency.
// - net and panel both rs485 gives panel priority; net entry refused.
// - changed settings take effect only at power-on or reset.
// - network and panel source settings are writable at all times.
// - option selected but absent refuses entry into network mode.
// - auto mode gives the network to rs485 without option unless the panel source is rs485, else option.
// - rs485 for both network and panel disables network switching.
// - panel key toggles panel and network mode; switch input level selects them; the code acts only when that level changes.
// - panel and network never swap directly; they pass through a step.
module css_selector
  import css_pkg::*;
(
  input wire logic clock,
  input wire logic rst,
  input wire logic ce,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic option_fitted,
  input wire logic mode_toggle_key,
  input wire logic panel_network_switch_in,
  input css_req_t [NUM_SRC-1:0] comm_req,
  output css_ans_t [NUM_SRC-1:0] comm_ans,
  output css_grant_t grant,
  output css_mode_t op_mode,
  output logic net_refused
);

  css_state_t s_r;
  css_state_t s_nxt;
  css_grant_t dec_grant;

  // true when a setting value lies in its range
  function automatic logic setting_ok(input logic [7:0] addr,
                                      input logic [31:0] d);
    logic ok;
    ok = 1'b1;
    unique case (addr)
      REG_RUN_SRC: ok = (d == 32'(RUN_COMM)) || (d == 32'(RUN_TERM));
      REG_SPEED_SRC: ok = (d == 32'(SPD_COMM)) || (d == 32'(SPD_ANALOG)) ||
                          (d == 32'(SPD_COMM_FREQ));
      REG_NET_SRC: ok = (d == 32'(NET_OPTION)) || (d == 32'(NET_RS485)) ||
                        (d == 32'(NET_AUTO));
      REG_PANEL_SRC: ok = (d == 32'(PNL_RS485)) || (d == 32'(PNL_CONN)) ||
                          (d == 32'(PNL_USB));
      default: ok = 1'b1;
    endcase
    return ok;
  endfunction : setting_ok

  // true for a mapped register offset
  function automatic logic addr_mapped(input logic [7:0] addr);
    return (addr == REG_RUN_SRC) || (addr == REG_SPEED_SRC) ||
           (addr == REG_NET_SRC) || (addr == REG_PANEL_SRC) ||
           (addr == REG_CTRL) || (addr == REG_STATUS);
  endfunction : addr_mapped

  css_grant_decode u_dec (
    .cfg(s_r.active),
    .opt(s_r.opt),
    .mode(s_nxt.mode),
    .grant(dec_grant)
  );

  logic setup;
  logic access_wr;
  logic wr_ok;
  logic key_ev;
  logic sw_ev;
  logic want_net;
  logic req_ev;
  logic refuse_ev;
  logic refused_clr;
  logic [31:0] status;

  always_comb begin
    s_nxt = s_r;
    setup = psel && !penable;
    access_wr = psel && penable && pwrite;
    wr_ok = access_wr && addr_mapped(paddr) && setting_ok(paddr, pwdata);
    refused_clr = 1'b0;
    status = '0;
    status[ST_MODE_LSB +: 2] = s_r.mode;
    status[ST_OPT_BIT] = s_r.opt;
    status[ST_NET_OK_BIT] = s_r.grant.net_allowed;
    status[ST_REFUSED_BIT] = s_r.refused;
    status[ST_PEND_BIT] = s_r.apply_pend;
    status[ST_SRC_LSB +: NUM_SRC] = s_r.grant.src;

    // setup phase: prepare read data and error answer
    if (setup) begin
      s_nxt.slverr = !addr_mapped(paddr) ||
                     (pwrite && !setting_ok(paddr, pwdata));
      s_nxt.rdata = '0;
      if (!pwrite) begin
        unique case (paddr)
          REG_RUN_SRC: s_nxt.rdata = 32'(s_r.staged.run);
          REG_SPEED_SRC: s_nxt.rdata = 32'(s_r.staged.speed);
          REG_NET_SRC: s_nxt.rdata = 32'(s_r.staged.net);
          REG_PANEL_SRC: s_nxt.rdata = 32'(s_r.staged.panel);
          REG_STATUS: s_nxt.rdata = status;
          default: s_nxt.rdata = '0;
        endcase
      end
    end

    // settings land in the staged copy whatever the mode
    if (wr_ok) begin
      unique case (paddr)
        REG_RUN_SRC: s_nxt.staged.run = pwdata[1:0];
        REG_SPEED_SRC: s_nxt.staged.speed = pwdata[1:0];
        REG_NET_SRC: s_nxt.staged.net = pwdata[13:0];
        REG_PANEL_SRC: s_nxt.staged.panel = pwdata[1:0];
        REG_CTRL: begin
          if (pwdata[CTRL_APPLY_BIT]) begin
            s_nxt.apply_pend = 1'b1;
          end
        end
        REG_STATUS: refused_clr = pwdata[ST_REFUSED_BIT];
        default: s_nxt.apply_pend = s_r.apply_pend;
      endcase
    end

    // mode requests from key and switch input
    key_ev = mode_toggle_key;
    sw_ev = (panel_network_switch_in != s_r.sw_prev);
    s_nxt.sw_prev = panel_network_switch_in;
    if (sw_ev) begin
      want_net = panel_network_switch_in;
    end else begin
      want_net = (s_r.mode == MODE_PANEL);
    end
    req_ev = (key_ev || sw_ev) && (s_r.mode != MODE_VIA);
    refuse_ev = 1'b0;

    unique case (s_r.mode)
      MODE_VIA: begin
        // one step outside both modes before entering the target
        s_nxt.mode = s_r.target;
      end
      default: begin
        if (req_ev) begin
          if (want_net && !s_r.grant.net_allowed) begin
            refuse_ev = 1'b1;
          end else if (want_net && s_r.mode != MODE_NET) begin
            s_nxt.target = MODE_NET;
            if (s_r.mode == MODE_PANEL) begin
              s_nxt.mode = MODE_VIA;
            end else begin
              s_nxt.mode = MODE_NET;
            end
          end else if (!want_net && s_r.mode != MODE_PANEL) begin
            s_nxt.target = MODE_PANEL;
            if (s_r.mode == MODE_NET) begin
              s_nxt.mode = MODE_VIA;
            end else begin
              s_nxt.mode = MODE_PANEL;
            end
          end
        end
      end
    endcase

    // sticky refusal flag, a new refusal beats the clear
    if (refuse_ev) begin
      s_nxt.refused = 1'b1;
    end else if (refused_clr) begin
      s_nxt.refused = 1'b0;
    end

    // power-on or reset request: latch settings and detect
    if (s_r.apply_pend) begin
      s_nxt.active = s_r.staged;
      s_nxt.opt = option_fitted;
      s_nxt.apply_pend = 1'b0;
      s_nxt.mode = MODE_EXT;
      s_nxt.target = MODE_EXT;
      s_nxt.refused = 1'b0;
    end

    // grants are decoded from the next mode and registered in step with it
    s_nxt.grant = dec_grant;
    if (s_r.apply_pend) begin
      s_nxt.grant.net_allowed = s_r.grant.net_allowed;
    end

    // answers to comm requests, one cycle later as pulses
    for (int i = 0; i < NUM_SRC; i++) begin
      s_nxt.ans[i] = '0;
      if (comm_req[i].valid) begin
        unique case (comm_req[i].kind)
          KIND_PWRITE: s_nxt.ans[i].accept = s_r.grant.src[i];
          KIND_RUN: s_nxt.ans[i].accept = s_r.grant.src[i] &&
                                          s_r.grant.run_comm;
          KIND_FREQ: s_nxt.ans[i].accept = s_r.grant.src[i] &&
                                           s_r.grant.speed_comm;
          default: s_nxt.ans[i].accept = 1'b1;
        endcase
        s_nxt.ans[i].reject = !s_nxt.ans[i].accept;
      end
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      s_r.staged <= '{run: RUN_INIT, speed: SPD_INIT, net: NET_INIT,
                      panel: PNL_INIT};
      s_r.active <= '{run: RUN_INIT, speed: SPD_INIT, net: NET_INIT,
                      panel: PNL_INIT};
      s_r.opt <= 1'b0;
      s_r.apply_pend <= 1'b1;
      s_r.mode <= MODE_EXT;
      s_r.target <= MODE_EXT;
      s_r.refused <= 1'b0;
      s_r.sw_prev <= 1'b0;
      s_r.grant <= '0;
      s_r.rdata <= '0;
      s_r.slverr <= 1'b0;
      s_r.ans <= '0;
    end else if (ce) begin
      s_r <= s_nxt;
    end
  end

  assign prdata = s_r.rdata;
  assign pslverr = s_r.slverr;
  assign pready = ce;
  assign comm_ans = s_r.ans;
  assign grant = s_r.grant;
  assign op_mode = s_r.mode;
  assign net_refused = s_r.refused;

endmodule : css_selector

// file: css_pkg.sv
// css_pkg: shared types and constants of the command source selector.
// assumes a 32-bit apb slave port and one system clock.
package css_pkg;

  // register byte offsets
  localparam logic [7:0] REG_RUN_SRC = 8'h00;
  localparam logic [7:0] REG_SPEED_SRC = 8'h04;
  localparam logic [7:0] REG_NET_SRC = 8'h08;
  localparam logic [7:0] REG_PANEL_SRC = 8'h0c;
  localparam logic [7:0] REG_CTRL = 8'h10;
  localparam logic [7:0] REG_STATUS = 8'h14;

  // setting encodings
  localparam logic [1:0] RUN_COMM = 2'h0;
  localparam logic [1:0] RUN_TERM = 2'h1;
  localparam logic [1:0] SPD_COMM = 2'h0;
  localparam logic [1:0] SPD_ANALOG = 2'h1;
  localparam logic [1:0] SPD_COMM_FREQ = 2'h2;
  localparam logic [13:0] NET_OPTION = 14'h0000;
  localparam logic [13:0] NET_RS485 = 14'h0001;
  localparam logic [13:0] NET_AUTO = 14'h270f;
  localparam logic [1:0] PNL_RS485 = 2'h1;
  localparam logic [1:0] PNL_CONN = 2'h2;
  localparam logic [1:0] PNL_USB = 2'h3;

  // reset values of the settings
  localparam logic [1:0] RUN_INIT = RUN_COMM;
  localparam logic [1:0] SPD_INIT = SPD_COMM;
  localparam logic [13:0] NET_INIT = NET_AUTO;
  localparam logic [1:0] PNL_INIT = PNL_CONN;

  // ctrl and status fields
  localparam int CTRL_APPLY_BIT = 0;
  localparam int ST_MODE_LSB = 0;
  localparam int ST_OPT_BIT = 2;
  localparam int ST_NET_OK_BIT = 3;
  localparam int ST_REFUSED_BIT = 4;
  localparam int ST_PEND_BIT = 5;
  localparam int ST_SRC_LSB = 8;

  // command sources
  localparam int NUM_SRC = 4;
  localparam int SRC_RS485 = 0;
  localparam int SRC_OPTION = 1;
  localparam int SRC_PANEL = 2;
  localparam int SRC_USB = 3;

  typedef enum logic [1:0] {
    MODE_EXT = 2'b00,
    MODE_PANEL = 2'b01,
    MODE_NET = 2'b10,
    MODE_VIA = 2'b11
  } css_mode_t;

  typedef enum logic [2:0] {
    KIND_MONITOR = 3'b000,
    KIND_PREAD = 3'b001,
    KIND_PWRITE = 3'b010,
    KIND_RUN = 3'b011,
    KIND_FREQ = 3'b100,
    KIND_RESET = 3'b101
  } css_kind_t;

  typedef struct packed {
    logic [1:0] run;
    logic [1:0] speed;
    logic [13:0] net;
    logic [1:0] panel;
  } css_cfg_t;

  typedef struct packed {
    logic [NUM_SRC-1:0] src;
    logic run_comm;
    logic run_term;
    logic speed_comm;
    logic speed_analog;
    logic net_allowed;
  } css_grant_t;

  typedef struct packed {
    logic valid;
    css_kind_t kind;
  } css_req_t;

  typedef struct packed {
    logic accept;
    logic reject;
  } css_ans_t;

  typedef struct packed {
    css_cfg_t staged;
    css_cfg_t active;
    logic opt;
    logic apply_pend;
    css_mode_t mode;
    css_mode_t target;
    logic refused;
    logic sw_prev;
    css_grant_t grant;
    logic [31:0] rdata;
    logic slverr;
    css_ans_t [NUM_SRC-1:0] ans;
  } css_state_t;

endpackage : css_pkg

// file: css_grant_decode.sv
// css_grant_decode: combinational grant decode from latched settings.
// assumes settings and option detect are already latched by the caller.
`timescale 1ns/10ps
module css_grant_decode
  import css_pkg::*;
(
  input css_cfg_t cfg,
  input wire logic opt,
  input css_mode_t mode,
  output css_grant_t grant
);

  logic net_opt;
  logic net_rs;

  always_comb begin
    // network owner
    net_opt = (cfg.net == NET_OPTION) ||
              ((cfg.net == NET_AUTO) && (opt || cfg.panel == PNL_RS485));
    net_rs = !net_opt && (cfg.panel != PNL_RS485);
    grant = '0;
    // option missing or rs485 held by panel: no network mode
    grant.net_allowed = net_opt ? opt : net_rs;
    unique case (mode)
      MODE_PANEL: begin
        unique case (cfg.panel)
          PNL_RS485: grant.src[SRC_RS485] = 1'b1;
          PNL_USB: grant.src[SRC_USB] = 1'b1;
          default: grant.src[SRC_PANEL] = 1'b1;
        endcase
        grant.run_comm = 1'b1;
        grant.speed_comm = 1'b1;
      end
      MODE_NET: begin
        // auto recognition with option fitted keeps rs485 out
        grant.src[SRC_OPTION] = net_opt;
        grant.src[SRC_RS485] = net_rs;
        grant.run_comm = (cfg.run == RUN_COMM);
        grant.run_term = (cfg.run == RUN_TERM);
        grant.speed_comm = (cfg.speed != SPD_ANALOG);
        grant.speed_analog = (cfg.speed == SPD_ANALOG);
      end
      default: begin
        grant.run_term = 1'b1;
        grant.speed_analog = 1'b1;
      end
    endcase
  end

endmodule : css_grant_decode

// file: css_selector_sva.sv
// css_selector_sva: port checker for css_selector.
// assumes ce held high; bound to the selector below.
`timescale 1ns/10ps
module css_selector_sva
  import css_pkg::*;
(
  input wire logic clock,
  input wire logic rst,
  input wire logic ce,
  input wire logic panel_network_switch_in,
  input css_req_t [NUM_SRC-1:0] comm_req,
  input css_ans_t [NUM_SRC-1:0] comm_ans,
  input css_grant_t grant,
  input css_mode_t op_mode,
  input wire logic net_refused
);
  default clocking @(posedge clock); endclocking
  default disable iff (rst);
  sequence s_rs485(css_kind_t k);
    ce && comm_req[SRC_RS485].valid && comm_req[SRC_RS485].kind == k;
  endsequence
  a_monitor_served: assert property (
    s_rs485(KIND_MONITOR) |=> comm_ans[SRC_RS485].accept)
    else $error("monitor not served");
  a_write_refused: assert property (
    s_rs485(KIND_PWRITE) ##0 !grant.src[SRC_RS485]
    |=> comm_ans[SRC_RS485].reject) else $error("write not refused");
  a_run_needs_grant: assert property (
    s_rs485(KIND_RUN) ##0 !grant.run_comm
    |=> comm_ans[SRC_RS485].reject) else $error("run not refused");
  a_freq_needs_grant: assert property (
    s_rs485(KIND_FREQ) ##0 !grant.speed_comm
    |=> comm_ans[SRC_RS485].reject) else $error("freq not refused");
  a_no_panel_net: assert property (
    op_mode == MODE_PANEL |=> op_mode != MODE_NET)
    else $error("panel to net direct");
  a_no_net_panel: assert property (
    op_mode == MODE_NET |=> op_mode != MODE_PANEL)
    else $error("net to panel direct");
  a_via_one_cycle: assert property (
    op_mode == MODE_VIA |=> op_mode != MODE_VIA)
    else $error("transit step too long");
  a_one_owner: assert property ($onehot0(grant.src))
    else $error("two owners");
  a_net_needs_allow: assert property (
    op_mode == MODE_NET |-> grant.net_allowed)
    else $error("net without allowance");
  a_refusal_flag: assert property (
    ce && $rose(panel_network_switch_in) && op_mode != MODE_VIA
    && !grant.net_allowed |=> net_refused && op_mode != MODE_NET)
    else $error("net entry not refused");
endmodule : css_selector_sva

bind css_selector css_selector_sva u_css_selector_sva (.clock(clock),
  .rst(rst), .ce(ce), .panel_network_switch_in(panel_network_switch_in),
  .comm_req(comm_req), .comm_ans(comm_ans), .grant(grant),
  .op_mode(op_mode), .net_refused(net_refused));

// file: css_net_master.sv
// css_net_master: network master model issuing comm requests.
// assumes answers come one edge after the request.
`timescale 1ns/10ps
module css_net_master
  import css_pkg::*;
(
  input wire logic clock,
  output css_req_t [NUM_SRC-1:0] comm_req,
  input css_ans_t [NUM_SRC-1:0] comm_ans
);
  // host never relies on rs485 panel mode for its protocol
  initial comm_req = '0;
  task send(input int i, input css_kind_t k, output logic [1:0] a);
    @(posedge clock);
    comm_req[i].valid <= 1'b1;
    comm_req[i].kind <= k;
    @(posedge clock);
    comm_req[i].valid <= 1'b0;
    comm_req[i].kind <= css_kind_t'(~k);
    // answer pulse stands until the next edge, so look mid-cycle
    @(negedge clock);
    a = {comm_ans[i].accept, comm_ans[i].reject};
  endtask : send
endmodule : css_net_master

// file: command_source_selector_bench.sv
// command_source_selector_bench: self-checking bench for css_selector.
// assumes ce stays high except one frozen stretch in t_rs485; the master model drives comm requests.
`timescale 1ns/10ps
module command_source_selector_bench
  import css_pkg::*;
;
  logic clock = 0, rst = 1, ce = 1, psel = 0, penable = 0, pwrite = 0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, q;
  logic pready, pslverr, e, net_refused, option_fitted = 0;
  logic mode_toggle_key = 0, panel_network_switch_in = 0;
  logic [1:0] ans;
  css_req_t [NUM_SRC-1:0] comm_req;
  css_ans_t [NUM_SRC-1:0] comm_ans;
  css_grant_t grant;
  css_mode_t op_mode;
  int error_cnt = 0, cmp_count = 0;
  css_selector u_css_selector (.clock, .rst, .ce, .psel, .penable, .pwrite,
    .paddr, .pwdata, .prdata, .pready, .pslverr, .option_fitted,
    .mode_toggle_key, .panel_network_switch_in, .comm_req, .comm_ans,
    .grant, .op_mode, .net_refused);
  css_net_master u_css_net_master (.clock, .comm_req, .comm_ans);
  always #10 clock = ~clock;
  task chk(input logic [31:0] g, x, input string m);
    cmp_count++;
    if (g !== x) begin
      error_cnt++;
      $display("BAD %0t %s", $time, m);
    end
  endtask : chk
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clock);
    psel <= 1;
    penable <= 0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clock);
    penable <= 1;
    @(posedge clock);
    while (pready !== 1'b1) @(posedge clock);
    q = prdata;
    e = pslverr;
    psel <= 0;
    penable <= 0;
  endtask : apb
  task apply;
    apb(1, REG_CTRL, 32'h1);
    repeat (3) @(posedge clock);
  endtask : apply
  task mode_req(input logic k, input logic s);
    @(posedge clock);
    mode_toggle_key <= k;
    panel_network_switch_in <= s;
    @(posedge clock);
    mode_toggle_key <= 0;
    repeat (2) @(posedge clock);
  endtask : mode_req
  task req(input int i, input css_kind_t k, input logic [1:0] x);
    u_css_net_master.send(i, k, ans);
    chk(32'(ans), 32'(x), "comm answer");
  endtask : req
  task t_regs;
    logic [7:0] a[4] = '{REG_RUN_SRC, REG_SPEED_SRC, REG_NET_SRC,
      REG_PANEL_SRC};
    logic [31:0] rv[4] = '{32'h0, 32'h0, 32'h270f, 32'h2};
    logic [31:0] hi[4] = '{32'h1, 32'h2, 32'h1, 32'h3};
    logic [31:0] bad[4] = '{32'h2, 32'h3, 32'h2, 32'h0};
    for (int i = 0; i < 4; i++) begin
      apb(0, a[i], 0);
      chk(q, rv[i], "reset value");
      apb(1, a[i], bad[i]);
      chk(e, 1, "bad value taken");
      apb(1, a[i], hi[i]);
      chk(e, 0, "write refused");
      apb(0, a[i], 0);
      chk(q, hi[i], "readback");
      apb(1, a[i], rv[i]);
    end
    apb(0, 8'h20, 0);
    chk(e, 1, "unmapped ok");
  endtask : t_regs
  task t_option;
    @(posedge clock);
    option_fitted <= 1;
    apply;
    mode_req(0, 1);
    chk(op_mode, MODE_NET, "not net");
    chk(grant.src, 4'h2, "option not owner");
    req(SRC_RS485, KIND_PWRITE, 2'b01);
    req(SRC_RS485, KIND_RUN, 2'b01);
    req(SRC_RS485, KIND_FREQ, 2'b01);
    req(SRC_RS485, KIND_PREAD, 2'b10);
    req(SRC_OPTION, KIND_RUN, 2'b10);
    req(SRC_OPTION, KIND_FREQ, 2'b10);
    mode_req(0, 0);
    chk(op_mode, MODE_PANEL, "not panel");
    chk(grant.src, 4'h4, "connector not owner");
  endtask : t_option
  task t_rs485;
    @(posedge clock);
    option_fitted <= 0;
    apply;
    mode_req(1, 0);
    mode_req(1, 0);
    chk(grant.src, 4'h1, "rs485 not owner");
    chk({grant.run_comm, grant.speed_comm}, 2'b11, "no comm");
    req(SRC_RS485, KIND_RUN, 2'b10);
    apb(1, REG_RUN_SRC, 32'h1);
    apb(1, REG_SPEED_SRC, 32'h1);
    chk(grant.run_comm, 1, "early change");
    apply;
    mode_req(0, 1);
    chk({grant.run_term, grant.speed_analog}, 2'b11, "no ext");
    req(SRC_RS485, KIND_RUN, 2'b01);
    req(SRC_RS485, KIND_FREQ, 2'b01);
    apb(1, REG_SPEED_SRC, 32'h2);
    apply;
    mode_req(0, 0);
    mode_req(0, 1);
    req(SRC_RS485, KIND_FREQ, 2'b10);
    apb(1, REG_NET_SRC, 32'h1);
    apb(1, REG_PANEL_SRC, 32'h1);
    apply;
    mode_req(0, 0);
    chk(grant.src, 4'h1, "rs485 panel");
    mode_req(0, 1);
    chk(net_refused, 1, "not refused");
    chk(op_mode, MODE_PANEL, "left panel");
    apb(0, REG_STATUS, 0);
    chk(32'(q[ST_REFUSED_BIT]), 1, "status refused");
    apb(1, REG_STATUS, 32'h10);
    @(negedge clock);
    chk(net_refused, 0, "refused not cleared");
    apb(1, REG_NET_SRC, 32'h0);
    apb(1, REG_PANEL_SRC, 32'h3);
    apply;
    mode_req(0, 0);
    chk(grant.src, 4'h8, "usb not owner");
    req(SRC_USB, KIND_MONITOR, 2'b10);
    req(SRC_USB, KIND_PWRITE, 2'b10);
    mode_req(0, 1);
    chk(net_refused, 1, "absent option taken");
    chk(op_mode, MODE_PANEL, "net without option");
    @(posedge clock);
    ce <= 0;
    mode_req(1, 0);
    chk(op_mode, MODE_PANEL, "moved while frozen");
    chk(net_refused, 1, "flag moved while frozen");
    @(posedge clock);
    ce <= 1;
    repeat (2) @(posedge clock);
  endtask : t_rs485
  task print_verdict;
    $display("compares %0d errors %0d", cmp_count, error_cnt);
    if (error_cnt == 0 && cmp_count > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : print_verdict
  initial begin
    #100000;
    error_cnt++;
    print_verdict;
  end
  initial begin
    repeat (5) @(posedge clock);
    rst <= 0;
    t_regs;
    t_option;
    t_rs485;
    print_verdict;
  end
endmodule : command_source_selector_bench
